// [rtl/ias_pkg.sv]
package ias_pkg;
   // ==========================================================
   // Sizes
   localparam int NSRC = 5;
   localparam int SRC_SER = 4;
   localparam int SRC_W = 3;
   localparam int PC_W = 12;
   localparam int CTX_W = 8;
   localparam int STK_DEPTH = 3;
   localparam int LVL_W = 2;
   localparam int EVT_W = 3;
   localparam int ADDR_W = 8;
   localparam int IDX_LSB = 2;
   localparam int ST_LSB = 2;
   // ==========================================================
   // Instruction cycle timing, 16 clocks of 4 states
   localparam logic [3:0] CNT_LAST = 4'hf;
   localparam logic [3:0] CNT_SAMPLE = 4'h8;
   localparam logic [3:0] CNT_ONE = 4'h1;
   // ==========================================================
   // Register indices, byte address is four times the index
   localparam logic [5:0] IDX_SER_REQ = 6'h2d;
   localparam logic [5:0] IDX_SER_EN = 6'h2e;
   localparam logic [5:0] IDX_STAT = 6'h30;
   localparam logic [5:0] IDX_IEN = 6'h31;
   localparam logic [5:0] IDX_ICLR = 6'h32;
   localparam int SER_BIT = 0;
   localparam logic SER_EN_RST = 1'h0;
   localparam logic [NSRC-1:0] SER_HOT = 5'h10;
   // ==========================================================
   // Event bits of the status register
   localparam int EVT_ACC = 0;
   localparam int EVT_OVF = 1;
   localparam int EVT_RET = 2;
   // ==========================================================
   // Rank k holds the source index at [k*SRC_W +: SRC_W], rank 0 first
   localparam logic [NSRC*SRC_W-1:0] PRIO_DEFAULT = 15'h4688;
   localparam logic [PC_W-1:0] VEC_BASE = 12'h001;
   typedef enum logic [1:0] {
      ST_M0 = 2'h0,
      ST_M1 = 2'h1,
      ST_M2 = 2'h2,
      ST_M3 = 2'h3
   } ias_state_e;
   typedef enum logic [1:0] {
      SEQ_RUN = 2'h0,
      SEQ_DEFER = 2'h1,
      SEQ_INT = 2'h2
   } ias_seq_e;
endpackage

// [rtl/ias_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module ias_sync (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Data
   input wire logic din,
   output logic dout
);
   logic ff1;
   logic ff2;
   logic ff3;
   // Output moves only once the last two stages agree
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ff1 <= 1'h0;
         ff2 <= 1'h0;
         ff3 <= 1'h0;
         dout <= 1'h0;
      end else begin
         ff1 <= din;
         ff2 <= ff1;
         ff3 <= ff2;
         if (ff2 == ff3) begin
            dout <= ff3;
         end
      end
   end
endmodule
`default_nettype wire

// [rtl/ias_stack.sv]
`timescale 1ns/1ps
`default_nettype none
module ias_stack import ias_pkg::*; (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Push and pop
   input wire logic push,
   input wire logic pop,
   input wire logic [CTX_W-1:0] wr_data,
   output logic [CTX_W-1:0] rd_data,
   // Fill state
   output logic full,
   output logic [LVL_W-1:0] level
);
   logic [CTX_W-1:0] mem [STK_DEPTH];
   localparam logic [LVL_W-1:0] DEPTH_L = LVL_W'(STK_DEPTH);
   localparam logic [LVL_W-1:0] ONE_L = 2'h1;
   wire do_push = push & ~full;
   wire do_pop = pop & (level != '0);
   assign full = (level == DEPTH_L);
   always_ff @(posedge clk_sys) begin
      if (do_push) begin
         mem[level] <= wr_data;
      end
   end
   // Popped entry leaves through a register one clock later
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         level <= '0;
         rd_data <= '0;
      end else if (do_pop) begin
         level <= level - ONE_L;
         rd_data <= mem[level - ONE_L];
      end else if (do_push) begin
         level <= level + ONE_L;
      end
   end
endmodule
`default_nettype wire

// [rtl/ias_top.sv]
// Operation
// - Four-bit register, bit0 enables serial interrupt; here only bit0 is stored, upper bits read zero
// - Serial disabled: request held, not serviced
// - Enabled, global on, flagged: serial serviced
// - Finish current instruction, then jump to vector
// - Table-move, enable, taken skip: two cycles later
// - Push return address and context one level
// - Highest priority first, lower ones stay pending
// - Return restores context, global enable unchanged
// - Enable instruction acts after following instruction
// - Sixteen clocks, four states of four
// - Requests sampled at start of third state
// - Enable, one more instruction, preparation, vector; here two instructions follow the enable before preparation
// - Preparation saves context, clears accepted request
// - Acceptance clears global enable
// - Interrupt stack holds three levels
// - Writing zero withdraws serial request
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ias_top import ias_pkg::*; #(
   parameter logic [NSRC*SRC_W-1:0] PRIO_ORDER = PRIO_DEFAULT
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Request sources
   input wire logic [NSRC-1:0] src_req,
   input wire logic [NSRC-1:0] src_enable,
   // Core sequencer
   input wire logic instr_table_move,
   input wire logic instr_enable_irq,
   input wire logic instr_disable_irq,
   input wire logic instr_irq_return,
   input wire logic instr_skip_taken,
   input wire logic [PC_W-1:0] return_pc,
   input wire logic [CTX_W-1:0] context_now,
   output ias_state_e instr_state,
   output logic instr_end,
   output logic irq_cycle,
   output logic addr_push,
   output logic [PC_W-1:0] addr_push_data,
   output logic vector_load,
   output logic [PC_W-1:0] vector_addr,
   output logic ctx_restore_valid,
   output logic [CTX_W-1:0] ctx_restore,
   output logic global_irq_enable,
   // Interrupt
   output logic irq
);
   // ==========================================================
   // Instruction cycle counter
   logic [3:0] cnt;
   ias_seq_e seq;
   wire [3:0] next_cnt = cnt + CNT_ONE;
   wire at_end = (cnt == CNT_LAST);
   wire at_sample = (cnt == CNT_SAMPLE);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
         instr_state <= ST_M0;
         instr_end <= 1'h0;
      end else begin
         cnt <= next_cnt;
         instr_state <= ias_state_e'(next_cnt[3:ST_LSB]);
         instr_end <= (next_cnt == CNT_LAST);
      end
   end

   // ==========================================================
   // APB decode
   logic serial_irq_enable;
   logic [NSRC-1:0] req_flag;
   logic [EVT_W-1:0] stat;
   logic [EVT_W-1:0] irq_en;
   wire [5:0] idx = paddr[ADDR_W-1:IDX_LSB];
   wire aligned = (paddr[IDX_LSB-1:0] == '0);
   wire hit_req = aligned & (idx == IDX_SER_REQ);
   wire hit_en = aligned & (idx == IDX_SER_EN);
   wire hit_stat = aligned & (idx == IDX_STAT);
   wire hit_ien = aligned & (idx == IDX_IEN);
   wire hit_iclr = aligned & (idx == IDX_ICLR);
   wire mapped = hit_req | hit_en | hit_stat | hit_ien | hit_iclr;
   wire apb_acc = psel & penable & ~pready;
   wire apb_wr = psel & penable & pready & pwrite;
   wire wr_req = apb_wr & hit_req;
   wire wr_en = apb_wr & hit_en;
   wire wr_ien = apb_wr & hit_ien;
   wire wr_iclr = apb_wr & hit_iclr;
   wire [31:0] rd_req = {31'h0000_0000, req_flag[SRC_SER]};
   wire [31:0] rd_en = {31'h0000_0000, serial_irq_enable};
   wire [31:0] rd_stat = {29'h0000_0000, stat};
   wire [31:0] rd_ien = {29'h0000_0000, irq_en};
   wire [31:0] rd_word = hit_req ? rd_req :
                         hit_en ? rd_en :
                         hit_stat ? rd_stat :
                         hit_ien ? rd_ien : 32'h0000_0000;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'h0;
         pslverr <= 1'h0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= apb_acc;
         pslverr <= apb_acc & ~mapped;
         prdata <= apb_acc ? rd_word : 32'h0000_0000;
      end
   end

   // Only bit 0 is stored; the upper bits have no storage
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         serial_irq_enable <= SER_EN_RST;
      end else if (wr_en) begin
         serial_irq_enable <= pwdata[SER_BIT];
      end
   end

   // ==========================================================
   // Request flags
   logic [NSRC-1:0] req_s;
   logic [NSRC-1:0] req_s_d;
   logic acc_go;
   logic [SRC_W-1:0] win_idx;
   logic win_any;
   wire sw_one = pwdata[SER_BIT];
   wire [NSRC-1:0] sw_set = (wr_req & sw_one) ? SER_HOT : '0;
   wire [NSRC-1:0] sw_clr = (wr_req & ~sw_one) ? SER_HOT : '0;
   wire [NSRC-1:0] en_vec = (src_enable & ~SER_HOT) | (serial_irq_enable ? SER_HOT : '0);
   wire [NSRC-1:0] cand = req_flag & en_vec;
   wire [NSRC-1:0] pending = cand & {NSRC{global_irq_enable}};
   generate
      for (genvar i = 0; i < NSRC; i++) begin : g_src
         wire acc_clr = acc_go & (win_idx == SRC_W'(i));
         wire rise = req_s[i] & ~req_s_d[i];
         ias_sync u_sync (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .din(src_req[i]),
            .dout(req_s[i])
         );
         // New request wins over a clear in the same clock
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               req_s_d[i] <= 1'h0;
               req_flag[i] <= 1'h0;
            end else begin
               req_s_d[i] <= req_s[i];
               req_flag[i] <= rise | sw_set[i] | (req_flag[i] & ~acc_clr & ~sw_clr[i]);
            end
         end
      end
   endgenerate

   // ==========================================================
   // Fixed ranking, rank 0 wins
   always_comb begin
      win_any = 1'h0;
      win_idx = '0;
      for (int k = NSRC - 1; k >= 0; k--) begin
         if (cand[PRIO_ORDER[k*SRC_W +: SRC_W]]) begin
            win_any = 1'h1;
            win_idx = PRIO_ORDER[k*SRC_W +: SRC_W];
         end
      end
   end

   // ==========================================================
   // Acceptance sequencer
   logic recog;
   logic ei_pend;
   logic [SRC_W-1:0] win_lat;
   wire in_int = (seq == SEQ_INT);
   wire dly = instr_table_move | instr_enable_irq | instr_skip_taken;
   wire go_run = (seq == SEQ_RUN) & recog & ~dly;
   wire go_defer = (seq == SEQ_RUN) & recog & dly;
   assign acc_go = at_end & win_any & (go_run | (seq == SEQ_DEFER));
   wire int_done = at_end & in_int;
   wire ret_go = at_end & ~in_int & instr_irq_return;
   wire [PC_W-1:0] next_vec = VEC_BASE + {{(PC_W - SRC_W){1'h0}}, win_lat};
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         seq <= SEQ_RUN;
      end else begin
         case (seq)
            SEQ_RUN: begin
               if (acc_go) begin
                  seq <= SEQ_INT;
               end else if (at_end & go_defer) begin
                  seq <= SEQ_DEFER;
               end
            end
            SEQ_DEFER: begin
               if (acc_go) begin
                  seq <= SEQ_INT;
               end else if (at_end) begin
                  seq <= SEQ_RUN;
               end
            end
            SEQ_INT: begin
               if (int_done) begin
                  seq <= SEQ_RUN;
               end
            end
            default: begin
               seq <= SEQ_RUN;
            end
         endcase
      end
   end

   // Recognition only at the first clock of the third state
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         recog <= 1'h0;
      end else if (at_end) begin
         recog <= 1'h0;
      end else if (at_sample & (seq == SEQ_RUN) & (|pending)) begin
         recog <= 1'h1;
      end
   end

   // Acceptance clears global enable even when a delayed set lands
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         global_irq_enable <= 1'h0;
         ei_pend <= 1'h0;
      end else begin
         if (acc_go) begin
            global_irq_enable <= 1'h0;
         end else if (at_end & ~in_int & instr_disable_irq) begin
            global_irq_enable <= 1'h0;
         end else if (at_end & ei_pend) begin
            global_irq_enable <= 1'h1;
         end
         if (at_end & ~in_int) begin
            ei_pend <= instr_enable_irq;
         end
      end
   end

   // ==========================================================
   // Context save and restore
   logic [CTX_W-1:0] stk_rd;
   logic stk_full;
   logic [LVL_W-1:0] stk_level;
   logic ret_d;
   ias_stack u_stack (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .push(acc_go),
      .pop(ret_go),
      .wr_data(context_now),
      .rd_data(stk_rd),
      .full(stk_full),
      .level(stk_level)
   );
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_cycle <= 1'h0;
         addr_push <= 1'h0;
         addr_push_data <= '0;
         win_lat <= '0;
         vector_load <= 1'h0;
         vector_addr <= '0;
         ret_d <= 1'h0;
         ctx_restore_valid <= 1'h0;
         ctx_restore <= '0;
      end else begin
         irq_cycle <= acc_go | (in_int & ~int_done);
         addr_push <= acc_go;
         if (acc_go) begin
            addr_push_data <= return_pc;
            win_lat <= win_idx;
         end
         vector_load <= int_done;
         if (int_done) begin
            vector_addr <= next_vec;
         end
         ret_d <= ret_go;
         ctx_restore_valid <= ret_d;
         if (ret_d) begin
            ctx_restore <= stk_rd;
         end
      end
   end

   // ==========================================================
   // Event status and interrupt output
   wire [EVT_W-1:0] evt = {ret_go, acc_go & stk_full, acc_go};
   wire [EVT_W-1:0] clr = wr_iclr ? pwdata[EVT_W-1:0] : '0;
   wire [EVT_W-1:0] next_stat = evt | (stat & ~clr);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stat <= '0;
         irq_en <= '0;
         irq <= 1'h0;
      end else begin
         stat <= next_stat;
         if (wr_ien) begin
            irq_en <= pwdata[EVT_W-1:0];
         end
         irq <= |(next_stat & (wr_ien ? pwdata[EVT_W-1:0] : irq_en));
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   AST_INSTR_LEN: assert property (instr_end |-> ##16 instr_end)
      else $error("instruction cycle is not 16 clocks");
   AST_STATE_LEN: assert property ($changed(instr_state) |=> $stable(instr_state) [*3])
      else $error("state shorter than 4 clocks");
   AST_SER_UPPER: assert property (pready && $past(hit_en) |-> prdata[31:1] == '0)
      else $error("enable register upper bits not zero");
   AST_HOLD: assert property (!serial_irq_enable && req_flag[SRC_SER] && !wr_req
                              |=> req_flag[SRC_SER])
      else $error("disabled serial request was dropped");
   AST_GIE_CLR: assert property (acc_go |=> !global_irq_enable && irq_cycle)
      else $error("global enable not cleared on acceptance");
   AST_VEC: assert property (acc_go |-> ##17 vector_load)
      else $error("vector not loaded after preparation cycle");
   AST_PUSH: assert property (acc_go |=> addr_push && addr_push_data == $past(return_pc))
      else $error("return address not pushed");
   AST_RET_GIE: assert property (ret_go && !acc_go && !ei_pend && !instr_disable_irq
                                 |=> $stable(global_irq_enable))
      else $error("return changed global enable");
   AST_EI_LATE: assert property ($rose(global_irq_enable) |-> $past(ei_pend))
      else $error("global enable set without delay");
   AST_DEFER: assert property (at_end && go_defer |=> seq == SEQ_DEFER ##15 !irq_cycle)
      else $error("deferred acceptance started early");
   AST_STACK: assert property (acc_go && stk_full && !ret_go |=> stk_level == LVL_W'(STK_DEPTH))
      else $error("interrupt stack level moved on overflow push");

   COV_ACCEPT: cover property (acc_go ##17 vector_load);
   COV_DEFER: cover property (at_end && go_defer ##16 acc_go);
   COV_RETURN: cover property (ret_go ##2 ctx_restore_valid);
   COV_OVF: cover property (acc_go && stk_full);
endmodule
`default_nettype wire

// [bench/ias_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ias_core_model import ias_pkg::*; (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Bench control
   input wire logic [4:0] op,
   input wire logic [NSRC-1:0] raise,
   // Current instruction kind
   output logic instr_table_move,
   output logic instr_enable_irq,
   output logic instr_disable_irq,
   output logic instr_irq_return,
   output logic instr_skip_taken,
   // Peripheral request lines
   output logic [NSRC-1:0] src_req
);
   logic [NSRC-1:0] raise_d;
   // ==========================================
   // Instruction decode, held for the whole cycle
   assign instr_table_move = op[0];
   assign instr_enable_irq = op[1];
   assign instr_disable_irq = op[2];
   assign instr_irq_return = op[3];
   assign instr_skip_taken = op[4];
   // ==========================================
   // Request line rises on an event, idles low after two clocks
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         raise_d <= '0;
         src_req <= '0;
      end else begin
         raise_d <= raise;
         src_req <= raise | raise_d;
      end
   end
endmodule
`default_nettype wire

// [bench/interrupt_accept_sequencer_test.sv]
`timescale 1ns/1ps
`default_nettype none
module interrupt_accept_sequencer_test import ias_pkg::*; ();
   localparam logic [7:0] A_REQ = {IDX_SER_REQ, 2'b00};
   localparam logic [7:0] A_EN = {IDX_SER_EN, 2'b00};
   localparam logic [7:0] A_STAT = {IDX_STAT, 2'b00};
   localparam logic [7:0] A_IEN = {IDX_IEN, 2'b00};
   localparam logic [7:0] A_CLR = {IDX_ICLR, 2'b00};
   localparam logic [4:0] O_NOP = 5'h00;
   localparam logic [4:0] O_EI = 5'h02;
   localparam logic [4:0] O_RET = 5'h08;
   localparam logic [4:0] L_OP [5] = '{5'h00, 5'h01, 5'h10, 5'h02, 5'h00};
   localparam int LAG [5] = '{0, 0, 0, 0, 9};
   localparam logic [4:0] DFR = 5'h1e;
   logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, er;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [NSRC-1:0] src_req, src_enable, raise;
   logic [4:0] op;
   logic i_tm, i_ei, i_di, i_ret, i_skip;
   logic [PC_W-1:0] return_pc, addr_push_data, vector_addr;
   logic [CTX_W-1:0] context_now, ctx_restore, last_ctx, ctx_seen;
   ias_state_e instr_state;
   logic instr_end, irq_cycle, addr_push, vector_load, ctx_restore_valid, global_irq_enable, irq;
   int error_cnt = 0;
   int num_checks = 0;
   int acc_cnt = 0;
   int acc;
   assign context_now = return_pc[CTX_W-1:0] ^ 8'ha5;
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   ias_top #(.PRIO_ORDER(PRIO_DEFAULT)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .src_req(src_req), .src_enable(src_enable), .instr_table_move(i_tm), .instr_enable_irq(i_ei),
      .instr_disable_irq(i_di), .instr_irq_return(i_ret), .instr_skip_taken(i_skip), .return_pc(return_pc),
      .context_now(context_now), .instr_state(instr_state), .instr_end(instr_end), .irq_cycle(irq_cycle),
      .addr_push(addr_push), .addr_push_data(addr_push_data), .vector_load(vector_load),
      .vector_addr(vector_addr), .ctx_restore_valid(ctx_restore_valid), .ctx_restore(ctx_restore),
      .global_irq_enable(global_irq_enable), .irq(irq));
   ias_core_model core_u (.clk_sys(clk_sys), .rst_n(rst_n), .op(op), .raise(raise), .instr_table_move(i_tm),
      .instr_enable_irq(i_ei), .instr_disable_irq(i_di), .instr_irq_return(i_ret), .instr_skip_taken(i_skip),
      .src_req(src_req));
   // ==========================================
   // Monitors
   always @(negedge clk_sys) begin
      if (ctx_restore_valid === 1'b1) ctx_seen = ctx_restore;
      if (addr_push === 1'b1) acc_cnt++;
   end
   // ==========================================
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      // Answer and read data are taken at the edge that samples pready high
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         error_cnt++;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(rd, exp);
   endtask
   task automatic irqc(input logic exp);
      repeat (2) @(negedge clk_sys);
      check(irq, exp);
   endtask
   task automatic exec(input logic [4:0] k);
      @(posedge clk_sys);
      op <= k;
      return_pc <= return_pc + 12'h001;
      do @(negedge clk_sys); while (!(instr_end === 1'b1 && irq_cycle !== 1'b1));
      @(posedge clk_sys);
      // Later cycles run as plain instructions, not as a repeat of this one
      op <= O_NOP;
   endtask
   task automatic pulse(input logic [NSRC-1:0] h);
      @(posedge clk_sys);
      raise <= h;
      @(posedge clk_sys);
      raise <= '0;
   endtask
   task automatic check_acc(input logic [PC_W-1:0] idx, input int w);
      int n;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (irq_cycle !== 1'b1 && n < w);
      check(addr_push, 1'b1);
      check(addr_push_data, return_pc);
      check(global_irq_enable, 1'b0);
      last_ctx = context_now;
      repeat (16) @(negedge clk_sys);
      check(irq_cycle, 1'b0);
      check(vector_load, 1'b1);
      check(vector_addr, VEC_BASE + idx);
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ==========================================
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      end_sim();
   end
   // ==========================================
   // Main sequence
   initial begin
      rst_n = 1'b0;
      {psel, penable, pwrite} = 3'h0;
      paddr = '0;
      pwdata = '0;
      op = '0;
      raise = '0;
      src_enable = 5'h0f;
      return_pc = 12'h100;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      do @(negedge clk_sys); while (instr_end !== 1'b1);
      repeat (9) @(negedge clk_sys);
      check(instr_state, ST_M2);
      repeat (7) @(negedge clk_sys);
      check(instr_end, 1'b1);
      rdc(A_EN, 32'h0000_0000);
      apb(1'b1, A_EN, 32'h0000_000f);
      rdc(A_EN, 32'h0000_0001);
      apb(1'b1, A_EN, 32'h0000_0000);
      apb(1'b0, 8'h04, 32'h0000_0000);
      check(er, 1'b1);
      apb(1'b1, A_IEN, 32'h0000_0007);
      apb(1'b1, A_REQ, 32'h0000_0001);
      exec(O_EI);
      @(negedge clk_sys);
      check(global_irq_enable, 1'b0);
      exec(O_NOP);
      @(negedge clk_sys);
      check(global_irq_enable, 1'b1);
      acc = acc_cnt;
      exec(O_NOP);
      exec(O_NOP);
      check(acc_cnt, acc);
      rdc(A_REQ, 32'h0000_0001);
      apb(1'b1, A_REQ, 32'h0000_0000);
      rdc(A_REQ, 32'h0000_0000);
      apb(1'b1, A_REQ, 32'h0000_0001);
      apb(1'b1, A_EN, 32'h0000_0001);
      check_acc(PC_W'(SRC_SER), 40);
      rdc(A_REQ, 32'h0000_0000);
      rdc(A_STAT, 32'h0000_0001);
      irqc(1'b1);
      apb(1'b1, A_IEN, 32'h0000_0000);
      irqc(1'b0);
      apb(1'b1, A_IEN, 32'h0000_0007);
      apb(1'b1, A_CLR, 32'h0000_0007);
      rdc(A_STAT, 32'h0000_0000);
      irqc(1'b0);
      exec(O_RET);
      exec(O_NOP);
      check(ctx_seen, last_ctx);
      check(global_irq_enable, 1'b0);
      pulse(5'h03);
      exec(O_EI);
      exec(O_NOP);
      exec(O_NOP);
      check_acc(12'h000, 1);
      exec(O_EI);
      exec(O_RET);
      exec(O_NOP);
      check_acc(12'h001, 1);
      for (int i = 0; i < 5; i++) begin
         exec(O_EI);
         exec(O_RET);
         fork
            begin
               repeat (LAG[i]) @(posedge clk_sys);
               pulse(5'h04);
            end
            exec(L_OP[i]);
         join
         if (DFR[i]) begin
            @(negedge clk_sys);
            check(irq_cycle, 1'b0);
            exec(O_NOP);
         end
         check_acc(12'h002, 1);
      end
      apb(1'b1, A_CLR, 32'h0000_0007);
      for (int i = 0; i < 3; i++) begin
         pulse(5'h08);
         exec(O_EI);
         exec(O_NOP);
         exec(O_NOP);
         check_acc(12'h003, 1);
         rdc(A_STAT, (i == 2) ? 32'h0000_0003 : 32'h0000_0001);
         apb(1'b1, A_CLR, 32'h0000_0007);
      end
      end_sim();
   end
endmodule
`default_nettype wire
